// [hdl/mhc_pkg.sv]
// Constants, register map and state type of the maintenance hours counter
package mhc_pkg;

  // Clock rate and the one-minute time base
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned MINUTE_S = 60;
  localparam longint unsigned TICK_CYCLES_L = longint'(CLK_HZ) * longint'(MINUTE_S);
  localparam int unsigned PRESC_W = 31;

  // Field widths and limits, interval and operating time held as hours plus minutes, time_to_go as minutes
  localparam int unsigned SI_H_W = 14;
  localparam int unsigned OT_H_W = 17;
  localparam int unsigned MIN_W = 6;
  localparam int unsigned TTG_W = 20;
  localparam int unsigned TOT_W = 23;
  localparam logic [16:0] SI_H_MAX = 17'h0270F;
  localparam logic [16:0] OT_H_MAX = 17'h1869F;
  localparam logic [16:0] MIN_MAX = 17'h0003B;
  localparam logic [TOT_W-1:0] MIN_PER_H = 23'h00003C;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_INTERVAL = 8'h04;
  localparam logic [7:0] ADDR_OPTIME = 8'h08;
  localparam logic [7:0] ADDR_TIME_TO_GO = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;

  // Field positions
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned CTRL_POLICY_BIT = 1;
  localparam int unsigned CTRL_EXT_BIT = 2;
  localparam int unsigned HOURS_LSB = 0;
  localparam int unsigned INTV_MIN_LSB = 16;
  localparam int unsigned OT_MIN_LSB = 24;
  localparam int unsigned EV_DUE_BIT = 0;
  localparam int unsigned EV_SAT_BIT = 1;

  // Reset values
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [1:0] IRQ_RST = 2'h0;
  localparam logic [SI_H_W-1:0] SI_H_RST = 14'h0000;
  localparam logic [MIN_W-1:0] MIN_RST = 6'h00;

  typedef struct packed {
    logic run;
    logic policy;
    logic ext_sel;
    logic [1:0] irq_mask;
    logic [1:0] irq_stat;
    logic [SI_H_W-1:0] si_h;
    logic [MIN_W-1:0] si_m;
    logic [TTG_W-1:0] si_seen;
    logic [OT_H_W-1:0] ot_h;
    logic [MIN_W-1:0] ot_m;
    logic [TTG_W-1:0] ttg;
    logic [PRESC_W-1:0] presc;
    logic mr_prev;
    logic ra_prev;
    logic due;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } mhc_state_t;

endpackage : mhc_pkg

// [hdl/mhc_hours_counter.sv]
// Maintenance operating-hours counter with APB registers and interrupt
// Operation
// - Rising edge of maint_reset clears due_flag, reloads time_to_go, keeps operating_time.
// - Rising edge of reset_all_input clears due_flag, zeroes operating_time, reloads time_to_go.
// - Monitor high advances operating_time up and time_to_go down; low freezes both.
// - due_flag is set once time_to_go has reached zero.
// - Reset-only policy: flag cleared while either reset input is high.
// - Reset-or-idle policy: flag also cleared while monitor_input is low.
// - service_interval holds 0..9999 hours and 0..59 minutes.
// - operating_time saturates at 99999 hours and stops counting.
// - Interval, time_to_go and operating_time survive a reset without cold_start; cold_start clears them.
// - operating_time keeps counting with monitor high whatever maint_reset does.
// - Presetting operating_time sets time_to_go to interval minus remainder.
// - No preset in run; interval change makes time_to_go equal new interval.
// - An interval taken from another block is read as whole hours.
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/100ps
module mhc_hours_counter
  import mhc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = int'(TICK_CYCLES_L)
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cold_start,
  // Program logic inputs
  input wire logic monitor_input,
  input wire logic maint_reset,
  input wire logic reset_all_input,
  input wire logic [15:0] ext_interval_hours,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Results
  output logic due_flag,
  output logic irq
);

  mhc_state_t s_reg;
  mhc_state_t s_next;

  function automatic logic [16:0] clamp17(input logic [16:0] v, input logic [16:0] lim);
    clamp17 = (v > lim) ? lim : v;
  endfunction : clamp17

  function automatic logic [TOT_W-1:0] to_minutes(input logic [OT_H_W-1:0] h, input logic [MIN_W-1:0] m);
    to_minutes = TOT_W'(h) * MIN_PER_H + TOT_W'(m);
  endfunction : to_minutes

  function automatic logic [TTG_W-1:0] preset_ttg(input logic [TTG_W-1:0] si, input logic [TOT_W-1:0] ot);
    logic [TOT_W-1:0] rem;
    rem = (si == '0) ? '0 : (ot % TOT_W'(si));
    preset_ttg = si - TTG_W'(rem);
  endfunction : preset_ttg

  logic [PRESC_W-1:0] tick_last;
  assign tick_last = PRESC_W'(TICK_CYCLES - 1);

  always_comb
  begin
    logic mr_edge;
    logic ra_edge;
    logic tick;
    logic clr;
    logic access;
    logic commit;
    logic hit;
    logic [1:0] ev;
    logic [1:0] w1c;
    logic [SI_H_W-1:0] si_eff_h;
    logic [MIN_W-1:0] si_eff_m;
    logic [TTG_W-1:0] si_tot;
    logic [OT_H_W-1:0] wr_h;
    logic [MIN_W-1:0] wr_m;
    logic [31:0] rd;
    s_next = s_reg;
    mr_edge = 1'b0;
    ra_edge = 1'b0;
    tick = 1'b0;
    clr = 1'b0;
    ev = 2'h0;
    w1c = 2'h0;
    hit = 1'b1;
    rd = 32'h00000000;
    wr_h = '0;
    wr_m = '0;
    si_eff_h = '0;
    si_eff_m = '0;
    si_tot = '0;
    access = psel & penable & ~s_reg.pready;
    commit = psel & penable & s_reg.pready & pwrite;

    // Edge detection against last cycle's level
    mr_edge = maint_reset & ~s_reg.mr_prev;
    ra_edge = reset_all_input & ~s_reg.ra_prev;
    s_next.mr_prev = maint_reset;
    s_next.ra_prev = reset_all_input;

    // External interval carries hours only, minutes forced to zero
    if (s_reg.ext_sel)
    begin
      si_eff_h = SI_H_W'(clamp17({1'b0, ext_interval_hours}, SI_H_MAX));
      si_eff_m = '0;
    end
    else
    begin
      si_eff_h = s_reg.si_h;
      si_eff_m = s_reg.si_m;
    end
    si_tot = TTG_W'(to_minutes(OT_H_W'(si_eff_h), si_eff_m));

    // Prescaler only advances on monitored on-time, so partial minutes are kept
    if (s_reg.run && monitor_input)
    begin
      if (s_reg.presc >= tick_last)
      begin
        s_next.presc = '0;
        tick = 1'b1;
      end
      else
      begin
        s_next.presc = s_reg.presc + PRESC_W'(1);
      end
    end

    // Minute step, independent of maint_reset
    if (tick)
    begin
      if (s_reg.ot_h != OT_H_W'(OT_H_MAX))
      begin
        if (s_reg.ot_m == MIN_W'(MIN_MAX))
        begin
          s_next.ot_m = '0;
          s_next.ot_h = s_reg.ot_h + OT_H_W'(1);
          if (s_next.ot_h == OT_H_W'(OT_H_MAX))
          begin
            s_next.ot_m = '0;
            ev[EV_SAT_BIT] = 1'b1;
          end
        end
        else
        begin
          s_next.ot_m = s_reg.ot_m + MIN_W'(1);
        end
      end
      if (s_reg.ttg != '0)
      begin
        s_next.ttg = s_reg.ttg - TTG_W'(1);
      end
    end

    // A changed interval replaces time_to_go outright
    if (si_tot != s_reg.si_seen)
    begin
      s_next.si_seen = si_tot;
      s_next.ttg = si_tot;
    end

    // Reset input edges
    if (mr_edge || ra_edge)
    begin
      s_next.ttg = si_tot;
    end
    if (ra_edge)
    begin
      s_next.ot_h = '0;
      s_next.ot_m = '0;
    end

    // Register read decode
    case (paddr)
      ADDR_CTRL:
        rd = 32'({s_reg.ext_sel, s_reg.policy, s_reg.run});
      ADDR_INTERVAL:
        rd = (32'(s_reg.si_m) << INTV_MIN_LSB) | (32'(s_reg.si_h) << HOURS_LSB);
      ADDR_OPTIME:
        rd = (32'(s_reg.ot_m) << OT_MIN_LSB) | (32'(s_reg.ot_h) << HOURS_LSB);
      ADDR_TIME_TO_GO:
        rd = 32'(s_reg.ttg);
      ADDR_STATUS:
        rd = 32'({(s_reg.ot_h == OT_H_W'(OT_H_MAX)), s_reg.due});
      ADDR_IRQ_STATUS:
        rd = 32'(s_reg.irq_stat);
      ADDR_IRQ_MASK:
        rd = 32'(s_reg.irq_mask);
      default:
      begin
        rd = 32'h00000000;
        hit = 1'b0;
      end
    endcase
    s_next.pready = access;
    s_next.prdata = (access && !pwrite) ? rd : 32'h00000000;
    s_next.pslverr = access & ~hit;

    // Register writes take effect at the completing edge
    if (commit)
    begin
      case (paddr)
        ADDR_CTRL:
        begin
          s_next.run = pwdata[CTRL_RUN_BIT];
          s_next.policy = pwdata[CTRL_POLICY_BIT];
          s_next.ext_sel = pwdata[CTRL_EXT_BIT];
        end
        ADDR_INTERVAL:
        begin
          s_next.si_h = SI_H_W'(clamp17(17'(pwdata[HOURS_LSB +: SI_H_W]), SI_H_MAX));
          s_next.si_m = MIN_W'(clamp17(17'(pwdata[INTV_MIN_LSB +: MIN_W]), MIN_MAX));
        end
        ADDR_OPTIME:
        begin
          // Preset refused in run mode
          if (!s_reg.run)
          begin
            wr_h = OT_H_W'(clamp17(pwdata[HOURS_LSB +: OT_H_W], OT_H_MAX));
            wr_m = MIN_W'(clamp17(17'(pwdata[OT_MIN_LSB +: MIN_W]), MIN_MAX));
            if (wr_h == OT_H_W'(OT_H_MAX))
            begin
              wr_m = '0;
            end
            s_next.ot_h = wr_h;
            s_next.ot_m = wr_m;
            s_next.si_seen = si_tot;
            s_next.ttg = preset_ttg(si_tot, to_minutes(wr_h, wr_m));
          end
        end
        ADDR_IRQ_STATUS:
          w1c = pwdata[1:0];
        ADDR_IRQ_MASK:
          s_next.irq_mask = pwdata[1:0];
        default:
          w1c = 2'h0;
      endcase
    end

    // Clearing conditions dominate the zero detect
    clr = maint_reset | reset_all_input;
    if (s_reg.policy && !monitor_input)
    begin
      clr = 1'b1;
    end
    s_next.due = ~clr & (s_next.ttg == '0);
    ev[EV_DUE_BIT] = s_next.due & ~s_reg.due;

    // Sticky events: a new event beats a same-cycle clear
    s_next.irq_stat = (s_reg.irq_stat & ~w1c) | ev;
    s_next.irq = |(s_next.irq_stat & s_next.irq_mask);

    // Synchronous reset; retentive values only cleared on a cold start
    if (rst)
    begin
      {s_next.ext_sel, s_next.policy, s_next.run} = CTRL_RST;
      s_next.irq_mask = IRQ_RST;
      s_next.irq_stat = IRQ_RST;
      s_next.presc = '0;
      s_next.mr_prev = 1'b0;
      s_next.ra_prev = 1'b0;
      s_next.due = 1'b0;
      s_next.irq = 1'b0;
      s_next.pready = 1'b0;
      s_next.pslverr = 1'b0;
      s_next.prdata = 32'h00000000;
      if (cold_start)
      begin
        s_next.si_h = SI_H_RST;
        s_next.si_m = MIN_RST;
        s_next.si_seen = '0;
        s_next.ot_h = '0;
        s_next.ot_m = MIN_RST;
        s_next.ttg = '0;
      end
      else
      begin
        s_next.si_h = s_reg.si_h;
        s_next.si_m = s_reg.si_m;
        s_next.si_seen = s_reg.si_seen;
        s_next.ot_h = s_reg.ot_h;
        s_next.ot_m = s_reg.ot_m;
        s_next.ttg = s_reg.ttg;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    s_reg <= s_next;
  end

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign due_flag = s_reg.due;
  assign irq = s_reg.irq;

endmodule : mhc_hours_counter

// [testbench/mhc_sva.sv]
// Port assertions for the hours counter
`timescale 1ns/100ps
module mhc_sva
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Program inputs
  input wire logic maint_reset,
  input wire logic reset_all_input,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Results
  input wire logic due_flag,
  input wire logic irq
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr outside answer");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h00000000)
    else $error("prdata not zero when idle");
  a_reset_clears: assert property ((maint_reset || reset_all_input) |=> !due_flag)
    else $error("due_flag high under reset input");
  a_due_rise: assert property ($rose(due_flag) |-> !$past(maint_reset) && !$past(reset_all_input))
    else $error("due_flag rose under reset input");
  a_sys_reset: assert property (disable iff (1'b0) rst |=> !due_flag && !irq && !pready)
    else $error("outputs not cleared by reset");
endmodule : mhc_sva

bind mhc_hours_counter mhc_sva mhc_sva_inst (.clk_sys(clk_sys), .rst(rst), .maint_reset(maint_reset),
  .reset_all_input(reset_all_input), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .due_flag(due_flag), .irq(irq));

// [testbench/mhc_prog_logic.sv]
// Program logic model driving the counter inputs
`timescale 1ns/100ps
module mhc_prog_logic
(
  // Clock
  input wire logic clk_sys,
  // Bench requests
  input wire logic mon_cmd,
  input wire logic mr_cmd,
  input wire logic ra_cmd,
  input wire logic [15:0] ext_cmd,
  // Counter inputs
  output logic monitor_input = 1'b0,
  output logic maint_reset = 1'b0,
  output logic reset_all_input = 1'b0,
  output logic [15:0] ext_interval_hours = 16'h0005
);
  // Levels move once a cycle, as a cyclic program would
  always @(posedge clk_sys)
  begin
    monitor_input <= mon_cmd;
    maint_reset <= mr_cmd;
    reset_all_input <= ra_cmd;
    ext_interval_hours <= ext_cmd;
  end
endmodule : mhc_prog_logic

// [testbench/testbench.sv]
// Self-checking bench for the hours counter
`timescale 1ns/100ps
module testbench;
  import mhc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cold_start = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [31:0] ttg_keep;
  logic pready, pslverr, due_flag, irq, err;
  logic monitor_input, maint_reset, reset_all_input;
  logic [15:0] ext_interval_hours;
  logic mon_cmd = 1'b0;
  logic mr_cmd = 1'b0;
  logic ra_cmd = 1'b0;
  logic [15:0] ext_cmd = 16'h0005;
  int mismatches = 0;
  int samples_checked = 0;

  always #25 clk_sys = ~clk_sys;

  // Short tick so a minute is four cycles
  mhc_hours_counter #(.TICK_CYCLES(4)) mhc_hours_counter_inst (.clk_sys(clk_sys), .rst(rst),
    .cold_start(cold_start), .monitor_input(monitor_input), .maint_reset(maint_reset),
    .reset_all_input(reset_all_input), .ext_interval_hours(ext_interval_hours), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .due_flag(due_flag), .irq(irq));
  mhc_prog_logic mhc_prog_logic_inst (.clk_sys(clk_sys), .mon_cmd(mon_cmd), .mr_cmd(mr_cmd),
    .ra_cmd(ra_cmd), .ext_cmd(ext_cmd), .monitor_input(monitor_input), .maint_reset(maint_reset),
    .reset_all_input(reset_all_input), .ext_interval_hours(ext_interval_hours));

  task automatic stop_test();
    if (mismatches == 0 && samples_checked > 0)
    begin
      $display("All checks passed");
    end
    else
    begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: %h vs %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  // One idle edge first, so psel is never set twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      mismatches++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(rd, exp);
  endtask : rdc

  task automatic wdue();
    int n;
    n = 0;
    while (due_flag !== 1'b1 && n < 200)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 200)
    begin
      mismatches++;
      stop_test();
    end
  endtask : wdue

  initial
  begin
    cyc(4);
    rst <= 1'b0;
    cold_start <= 1'b0;
    rdc(ADDR_CTRL, 32'h00000000);
    rdc(ADDR_IRQ_MASK, 32'h00000000);
    rdc(8'h1C, 32'h00000000);
    chk(32'(err), 32'h00000001);
    wr(ADDR_INTERVAL, 32'h0000001E);
    wr(ADDR_OPTIME, 32'h00000064);
    rdc(ADDR_TIME_TO_GO, 32'h000004B0);
    wr(ADDR_IRQ_STATUS, 32'h00000003);
    wr(ADDR_IRQ_MASK, 32'h00000001);
    wr(ADDR_CTRL, 32'h00000001);
    wr(ADDR_OPTIME, 32'h00000000);
    rdc(ADDR_OPTIME, 32'h00000064);
    wr(ADDR_INTERVAL, 32'h00030000);
    rdc(ADDR_TIME_TO_GO, 32'h00000003);
    mon_cmd <= 1'b1;
    wdue();
    mon_cmd <= 1'b0;
    rdc(ADDR_OPTIME, 32'h03000064);
    chk(32'(irq), 32'h00000001);
    cyc(20);
    rdc(ADDR_OPTIME, 32'h03000064);
    chk(32'(due_flag), 32'h00000001);
    mr_cmd <= 1'b1;
    cyc(3);
    chk(32'(due_flag), 32'h00000000);
    rdc(ADDR_TIME_TO_GO, 32'h00000003);
    rdc(ADDR_OPTIME, 32'h03000064);
    mon_cmd <= 1'b1;
    cyc(30);
    apb(1'b0, ADDR_OPTIME, 32'h00000000);
    chk(32'(rd[29:24] > 6'h05), 32'h00000001);
    chk(32'(due_flag), 32'h00000000);
    mr_cmd <= 1'b0;
    wdue();
    wr(ADDR_IRQ_STATUS, 32'h00000001);
    cyc(2);
    chk(32'(irq), 32'h00000000);
    wr(ADDR_IRQ_MASK, 32'h00000000);
    wr(ADDR_CTRL, 32'h00000003);
    mon_cmd <= 1'b0;
    cyc(3);
    chk(32'(due_flag), 32'h00000000);
    mon_cmd <= 1'b1;
    wdue();
    rdc(ADDR_IRQ_STATUS, 32'h00000001);
    chk(32'(irq), 32'h00000000);
    mon_cmd <= 1'b0;
    ra_cmd <= 1'b1;
    cyc(3);
    ra_cmd <= 1'b0;
    rdc(ADDR_OPTIME, 32'h00000000);
    rdc(ADDR_TIME_TO_GO, 32'h00000003);
    wr(ADDR_CTRL, 32'h00000000);
    wr(ADDR_INTERVAL, 32'h003F3FFF);
    rdc(ADDR_INTERVAL, 32'h003B270F);
    wr(ADDR_CTRL, 32'h00000004);
    ext_cmd <= 16'h2EE0;
    cyc(4);
    rdc(ADDR_TIME_TO_GO, 32'h00092784);
    wr(ADDR_CTRL, 32'h00000000);
    wr(ADDR_OPTIME, 32'h3B01869E);
    wr(ADDR_CTRL, 32'h00000001);
    mon_cmd <= 1'b1;
    cyc(40);
    rdc(ADDR_OPTIME, 32'h0001869F);
    apb(1'b0, ADDR_STATUS, 32'h00000000);
    chk(32'(rd[1]), 32'h00000001);
    rdc(ADDR_IRQ_STATUS, 32'h00000003);
    // Warm reset in mid-run with counting stopped; retentive values must survive
    mon_cmd <= 1'b0;
    cyc(3);
    apb(1'b0, ADDR_TIME_TO_GO, 32'h00000000);
    ttg_keep = rd;
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    rdc(ADDR_TIME_TO_GO, ttg_keep);
    rdc(ADDR_OPTIME, 32'h0001869F);
    rdc(ADDR_INTERVAL, 32'h003B270F);
    rdc(ADDR_CTRL, 32'h00000000);
    rdc(ADDR_IRQ_STATUS, 32'h00000000);
    stop_test();
  end
endmodule : testbench
